//--- rtl/csmp_cfg.svh
// Constants for the cache SRAM memory bus port: widths, reset values, index masks.
// Assumes inclusion by csmp_pkg.sv and csmp_port.sv only.
`ifndef CSMP_CFG_SVH
`define CSMP_CFG_SVH

// ************************************************************
// Widths
// ************************************************************
`define CSMP_DATA_W      8
`define CSMP_LINE_WORDS  8
`define CSMP_IDX_W       3

// ************************************************************
// Reset values, index masks and configuration wait count
// ************************************************************
`define CSMP_RST_BYTE    8'h00
`define CSMP_RST_IDX     3'h0
`define CSMP_MASK_FOUR   3'h3
`define CSMP_MASK_EIGHT  3'h7
`define CSMP_CFG_WAIT    2'h2

`endif

//--- rtl/csmp_pkg.sv
// Types of the cache SRAM memory bus port.
// Assumes csmp_cfg.svh is on the include path.
`include "csmp_cfg.svh"

package csmp_pkg;

  typedef logic [`CSMP_DATA_W-1:0]                       csmp_byte_t;
  typedef logic [`CSMP_IDX_W-1:0]                        csmp_idx_t;
  typedef logic [`CSMP_LINE_WORDS-1:0][`CSMP_DATA_W-1:0] csmp_line_t;

  typedef enum logic [1:0] {
    CSMP_MODE_STROBED = 2'b01,
    CSMP_MODE_CLOCKED = 2'b10
  } csmp_mode_t;

  // Pins seen from the core clock domain
  typedef struct packed {
    logic       sense;
    logic       ostb;
    logic       istb;
    logic       eoc_n;
    logic       sel_n;
    logic       zbt_n;
    logic       oe_n;
    csmp_byte_t data;
  } csmp_pins_t;

  typedef struct packed {
    csmp_pins_t s1;
    csmp_pins_t s2;
    csmp_pins_t prev;
    csmp_mode_t mode;
    logic [1:0] cfg_wait;
    logic       cfg_taken;
    logic       four;
    csmp_idx_t  cnt;
    logic       zbt;
    csmp_byte_t out;
    csmp_line_t rx;
    csmp_line_t rx_line;
    logic       done;
    csmp_line_t tx_hold;
    csmp_idx_t  start_hold;
    logic       tx_tgl;
    logic       rx_s1;
    logic       rx_s2;
    logic       rx_prev;
  } csmp_core_st_t;

  typedef struct packed {
    logic       mode_s1;
    logic       mode_s2;
    logic       four_s1;
    logic       four_s2;
    logic       tx_s1;
    logic       tx_s2;
    logic       tx_prev;
    csmp_line_t tx;
    csmp_idx_t  start;
    csmp_line_t rx;
    csmp_line_t rx_hold;
    logic       rx_tgl;
    csmp_idx_t  cnt;
    logic       zbt;
    csmp_byte_t out;
  } csmp_link_st_t;

endpackage

//--- rtl/csmp_port.sv
// Memory bus port of a cache data SRAM slice: line buffers, burst counter, mode sense.
// Assumes memory bus pins synchronous to strobe_mode_sense in clocked mode,
// and a core on clk that loads and collects whole lines.
`timescale 1ns/1ps
`include "csmp_cfg.svh"

module csmp_port (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 strobe_mode_sense,
  input  wire logic                 output_latch_clock,
  input  wire logic                 burst_ready_n,
  input  wire logic                 port_select_n,
  input  wire logic                 end_of_cycle_n,
  input  wire logic                 zero_based_burst_n,
  input  wire logic                 data_oe_n,
  input  wire csmp_pkg::csmp_byte_t memory_data_pins_in,
  output logic                      memory_data_pins_oe,
  output csmp_pkg::csmp_byte_t      memory_data_pins_out,
  input  wire logic                 core_tx_load,
  input  wire csmp_pkg::csmp_line_t core_tx_line,
  input  wire csmp_pkg::csmp_idx_t  core_start_idx,
  output csmp_pkg::csmp_line_t      core_rx_line,
  output logic                      core_rx_done,
  output logic                      clocked_mode,
  output logic                      four_xfers
);
  import csmp_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic csmp_idx_t idx_next(input csmp_idx_t i, input logic four);
    csmp_idx_t m;
    m = four ? `CSMP_MASK_FOUR : `CSMP_MASK_EIGHT;
    return csmp_idx_t'(i + csmp_idx_t'(1)) & m;
  endfunction

  function automatic csmp_idx_t idx_start(input csmp_idx_t s, input logic zbt,
                                          input logic four);
    csmp_idx_t m;
    m = four ? `CSMP_MASK_FOUR : `CSMP_MASK_EIGHT;
    return zbt ? `CSMP_RST_IDX : (s & m);
  endfunction

  csmp_core_st_t c_r;
  csmp_core_st_t c_nxt;
  csmp_link_st_t l_r;
  csmp_link_st_t l_nxt;
  csmp_pins_t    pins_now;
  csmp_byte_t    latch_q;
  logic          strobed;
  logic          sel_act;
  logic          ev_sense;
  logic          ev_istb;
  logic          ev_ostb;
  logic          ev_eoc;
  logic          ev_rx;
  logic          l_ev_tx;

  // ************************************************************
  // Core domain: synchronisers, mode sense, strobed engine
  // ************************************************************
  // Shared pins: latch clock doubles as output strobe, burst ready as input strobe
  always_comb begin
    pins_now.sense = strobe_mode_sense;
    pins_now.ostb  = output_latch_clock;
    pins_now.istb  = burst_ready_n;
    pins_now.eoc_n = end_of_cycle_n;
    pins_now.sel_n = port_select_n;
    pins_now.zbt_n = zero_based_burst_n;
    pins_now.oe_n  = data_oe_n;
    pins_now.data  = memory_data_pins_in;
  end

  assign strobed  = (c_r.mode == CSMP_MODE_STROBED);
  assign sel_act  = ~c_r.s2.sel_n;
  assign ev_sense = c_r.s2.sense ^ c_r.prev.sense;
  assign ev_istb  = c_r.s2.istb ^ c_r.prev.istb;
  assign ev_ostb  = c_r.s2.ostb ^ c_r.prev.ostb;
  assign ev_eoc   = c_r.prev.eoc_n & ~c_r.s2.eoc_n;
  assign ev_rx    = c_r.rx_s2 ^ c_r.rx_prev;

  always_comb begin
    c_nxt         = c_r;
    c_nxt.s1      = pins_now;
    c_nxt.s2      = c_r.s1;
    c_nxt.prev    = c_r.s2;
    c_nxt.rx_s1   = l_r.rx_tgl;
    c_nxt.rx_s2   = c_r.rx_s1;
    c_nxt.rx_prev = c_r.rx_s2;
    c_nxt.done    = 1'b0;
    if (ev_sense && c_r.cfg_taken) begin
      c_nxt.mode = CSMP_MODE_CLOCKED;
    end
    if (!c_r.cfg_taken) begin
      if (c_r.cfg_wait == `CSMP_CFG_WAIT) begin
        c_nxt.cfg_taken = 1'b1;
        c_nxt.four      = c_r.s2.sel_n;
      end else begin
        c_nxt.cfg_wait = 2'(c_r.cfg_wait + 2'h1);
      end
    end
    if (core_tx_load) begin
      c_nxt.tx_hold    = core_tx_line;
      c_nxt.start_hold = core_start_idx;
      c_nxt.tx_tgl     = ~c_r.tx_tgl;
    end
    // Line finished on the memory clock side, hold register is stable
    if (ev_rx) begin
      c_nxt.rx_line = l_r.rx_hold;
      c_nxt.done    = 1'b1;
    end
    if (strobed && c_r.cfg_taken) begin
      if (!sel_act) begin
        c_nxt.cnt = idx_start(c_r.start_hold, c_r.zbt, c_r.four);
        c_nxt.out = c_r.tx_hold[c_nxt.cnt];
      end else if (ev_eoc) begin
        c_nxt.zbt     = ~c_r.s2.zbt_n;
        c_nxt.cnt     = idx_start(c_r.start_hold, ~c_r.s2.zbt_n, c_r.four);
        c_nxt.out     = c_r.tx_hold[c_nxt.cnt];
        c_nxt.rx_line = c_r.rx;
        c_nxt.done    = 1'b1;
      end else if (ev_istb) begin
        c_nxt.rx[c_r.cnt] = c_r.s2.data;
        c_nxt.cnt         = idx_next(c_r.cnt, c_r.four);
      end else if (ev_ostb) begin
        c_nxt.cnt = idx_next(c_r.cnt, c_r.four);
        c_nxt.out = c_r.tx_hold[c_nxt.cnt];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_r            <= '0;
      c_r.mode       <= CSMP_MODE_STROBED;
      // Drive enable and select synchronisers start at idle pin levels: no drive, no select
      c_r.s1.oe_n    <= 1'b1;
      c_r.s2.oe_n    <= 1'b1;
      c_r.s1.sel_n   <= 1'b1;
      c_r.s2.sel_n   <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ************************************************************
  // Memory clock domain: clocked mode engine
  // ************************************************************
  assign l_ev_tx = l_r.tx_s2 ^ l_r.tx_prev;

  always_comb begin
    l_nxt         = l_r;
    l_nxt.mode_s1 = (c_r.mode == CSMP_MODE_CLOCKED);
    l_nxt.mode_s2 = l_r.mode_s1;
    l_nxt.four_s1 = c_r.four;
    l_nxt.four_s2 = l_r.four_s1;
    l_nxt.tx_s1   = c_r.tx_tgl;
    l_nxt.tx_s2   = l_r.tx_s1;
    l_nxt.tx_prev = l_r.tx_s2;
    // Hold register on the core side is stable while the toggle travels
    if (l_ev_tx) begin
      l_nxt.tx    = c_r.tx_hold;
      l_nxt.start = c_r.start_hold;
    end
    if (l_r.mode_s2) begin
      if (port_select_n) begin
        l_nxt.zbt = ~zero_based_burst_n;
        l_nxt.cnt = idx_start(l_r.start, ~zero_based_burst_n, l_r.four_s2);
        l_nxt.out = l_r.tx[l_nxt.cnt];
      end else if (!end_of_cycle_n) begin
        l_nxt.zbt     = ~zero_based_burst_n;
        l_nxt.cnt     = idx_start(l_r.start, ~zero_based_burst_n, l_r.four_s2);
        l_nxt.out     = l_r.tx[l_nxt.cnt];
        l_nxt.rx_hold = l_r.rx;
        l_nxt.rx_tgl  = ~l_r.rx_tgl;
      end else if (!burst_ready_n) begin
        l_nxt.rx[l_r.cnt] = memory_data_pins_in;
        l_nxt.cnt         = idx_next(l_r.cnt, l_r.four_s2);
        l_nxt.out         = l_r.tx[l_nxt.cnt];
      end
    end
  end

  always_ff @(posedge strobe_mode_sense or posedge reset) begin
    if (reset) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ************************************************************
  // Output latch and pins
  // ************************************************************
  always_latch begin
    if (output_latch_clock) begin
      latch_q <= l_r.out;
    end
  end

  assign memory_data_pins_out = strobed ? c_r.out : latch_q;
  assign memory_data_pins_oe  = ~c_r.s2.oe_n;
  assign core_rx_line         = c_r.rx_line;
  assign core_rx_done         = c_r.done;
  assign clocked_mode         = (c_r.mode == CSMP_MODE_CLOCKED);
  assign four_xfers           = c_r.four;

  // ************************************************************
  // Checks, core domain
  // ************************************************************
  AST_MODE_STICKY: assert property (@(posedge clk) disable iff (reset)
    (c_r.mode == CSMP_MODE_CLOCKED) |=> (c_r.mode == CSMP_MODE_CLOCKED))
    else $error("clocked mode lost");

  AST_MODE_DETECT: assert property (@(posedge clk) disable iff (reset)
    (ev_sense && c_r.cfg_taken) |=> clocked_mode)
    else $error("mode sense toggle not detected");

  AST_CFG_HOLD: assert property (@(posedge clk) disable iff (reset)
    c_r.cfg_taken |=> (c_r.cfg_taken && $stable(four_xfers)))
    else $error("transfer count changed after reset");

  AST_STB_IN: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && !ev_eoc && ev_istb)
    |=> (c_r.cnt == idx_next($past(c_r.cnt), c_r.four)
         && c_r.rx[$past(c_r.cnt)] == $past(c_r.s2.data)))
    else $error("input strobe edge not taken");

  AST_STB_OUT: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && !ev_eoc && !ev_istb && ev_ostb)
    |=> (memory_data_pins_out == c_r.tx_hold[idx_next($past(c_r.cnt), c_r.four)]))
    else $error("output strobe edge gave wrong word");

  AST_STB_QUAL: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && !sel_act && !core_tx_load)
    |=> (c_r.cnt == idx_start(c_r.start_hold, c_r.zbt, c_r.four)))
    else $error("strobes acted without select");

  AST_STB_EOC: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && ev_eoc)
    |=> (core_rx_done && c_r.zbt == !$past(c_r.s2.zbt_n)))
    else $error("end of cycle not completed");

  AST_ZBT_ZERO: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && ev_eoc && !c_r.s2.zbt_n)
    |=> (c_r.cnt == `CSMP_RST_IDX))
    else $error("zero based burst did not start at zero");

  AST_CFG_TAKE: assert property (@(posedge clk) disable iff (reset)
    (!c_r.cfg_taken && c_r.cfg_wait == `CSMP_CFG_WAIT)
    |=> (c_r.cfg_taken && four_xfers == $past(c_r.s2.sel_n)))
    else $error("transfer count not taken from select");

  AST_MODE_QUIET: assert property (@(posedge clk) disable iff (reset)
    !c_r.cfg_taken |=> strobed)
    else $error("mode changed before configuration");

  AST_STB_EOC_START: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && ev_eoc && c_r.s2.zbt_n && !core_tx_load)
    |=> (c_r.cnt == (c_r.start_hold
                     & (c_r.four ? `CSMP_MASK_FOUR : `CSMP_MASK_EIGHT))))
    else $error("end of cycle did not reload the start word");

  AST_STB_PRIO: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && sel_act && ev_eoc && ev_istb)
    |=> (c_r.rx == $past(c_r.rx)))
    else $error("input strobe taken on end of cycle");

  AST_STB_HOLD: assert property (@(posedge clk) disable iff (reset)
    (strobed && c_r.cfg_taken && !sel_act)
    |=> (c_r.rx == $past(c_r.rx)))
    else $error("input strobe taken without select");

  // ************************************************************
  // Checks, memory clock domain
  // ************************************************************
  AST_LNK_IDLE: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && port_select_n && !zero_based_burst_n)
    |=> (l_r.zbt && l_r.cnt == `CSMP_RST_IDX))
    else $error("idle zero based burst not sampled");

  AST_LNK_BRDY: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && !port_select_n && end_of_cycle_n && !burst_ready_n)
    |=> (l_r.cnt == idx_next($past(l_r.cnt), l_r.four_s2)))
    else $error("burst ready not honoured");

  AST_LNK_EOC: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && !port_select_n && !end_of_cycle_n)
    |=> ($changed(l_r.rx_tgl) && l_r.zbt == !$past(zero_based_burst_n)))
    else $error("clocked end of cycle not handed over");

  AST_LNK_DESEL: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && port_select_n)
    |=> (l_r.cnt == idx_start($past(l_r.start), !$past(zero_based_burst_n),
                              $past(l_r.four_s2))))
    else $error("burst counter not held at start while deselected");

  AST_LNK_RX: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && !port_select_n && end_of_cycle_n && !burst_ready_n)
    |=> (l_r.rx[$past(l_r.cnt)] == $past(memory_data_pins_in)))
    else $error("clocked data word not stored");

  AST_LNK_NOBRDY: assert property (@(posedge strobe_mode_sense) disable iff (reset)
    (l_r.mode_s2 && !port_select_n && end_of_cycle_n && burst_ready_n)
    |=> ($stable(l_r.cnt) && $stable(l_r.rx)))
    else $error("burst counter moved without burst ready");

  // ************************************************************
  // Checks, output latch
  // ************************************************************
  AST_LATCH_OPEN: assert property (@(posedge clk) disable iff (reset)
    (clocked_mode && output_latch_clock) |-> (memory_data_pins_out == l_r.out))
    else $error("open output latch did not pass the word");

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (reset)
    (clocked_mode && !output_latch_clock && $past(clocked_mode) && !$past(output_latch_clock))
    |-> $stable(memory_data_pins_out))
    else $error("closed output latch let the word change");

  COV_CLOCKED: cover property (@(posedge clk) disable iff (reset)
    $rose(clocked_mode));
  COV_STB_LINE: cover property (@(posedge clk) disable iff (reset)
    strobed && core_rx_done);
  COV_LNK_LINE: cover property (@(posedge clk) disable iff (reset)
    clocked_mode && core_rx_done);
  COV_LATCH: cover property (@(posedge strobe_mode_sense) disable iff (reset)
    l_r.mode_s2 && !output_latch_clock && !burst_ready_n && !port_select_n);
  COV_LNK_ZBT: cover property (@(posedge strobe_mode_sense) disable iff (reset)
    l_r.mode_s2 && port_select_n && !zero_based_burst_n);

endmodule

//--- testbench/csmp_mbc_model.sv
// Memory bus controller model: drives selects, strobes, end of cycle and memory clock.
// Assumes a testbench that calls its tasks one at a time from a single process.
`timescale 1ns/1ps

module csmp_mbc_model (
  output logic                 mclk,
  output logic                 olc,
  output logic                 brdy_n,
  output logic                 sel_n,
  output logic                 eoc_n,
  output logic                 zbt_n,
  output csmp_pkg::csmp_byte_t data
);
  import csmp_pkg::*;

  // ************************************************************
  // Idle levels; memory clock stands still outside frames
  // ************************************************************
  initial begin
    mclk   = 1'b0;
    olc    = 1'b0;
    brdy_n = 1'b1;
    sel_n  = 1'b1;
    eoc_n  = 1'b1;
    zbt_n  = 1'b1;
    data   = 8'h00;
  end

  // ************************************************************
  // Strobed mode cycles
  // ************************************************************
  task automatic sel(logic v);
    sel_n = v;
    #30;
  endtask

  task automatic ostb;
    olc = ~olc;
    #30;
  endtask

  task automatic istb(csmp_byte_t d);
    data = d;
    #10;
    brdy_n = ~brdy_n;
    #20;
    data = ~d;
    #10;
  endtask

  task automatic eoc(logic z);
    zbt_n = z;
    #10;
    eoc_n = 1'b0;
    #40;
    eoc_n = 1'b1;
    zbt_n = 1'b1;
    #30;
  endtask

  // ************************************************************
  // Clocked mode: one 64 ns memory clock period
  // ************************************************************
  task automatic mcyc(logic b, logic s, logic e, logic z, logic o, csmp_byte_t d);
    brdy_n = b;
    sel_n  = s;
    eoc_n  = e;
    zbt_n  = z;
    olc    = o;
    data   = d;
    #32;
    mclk = 1'b1;
    #16;
    data = ~d;
    #16;
    mclk = 1'b0;
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the cache SRAM memory bus port.
// Assumes csmp_port and csmp_mbc_model are compiled before it.
`timescale 1ns/1ps

module testbench;
  import csmp_pkg::*;
  logic       clk, reset, oe_n, load, mclk, olc, brdy_n, sel_n, eoc_n, zbt_n, oe, done, cm, four;
  csmp_byte_t din, dout;
  csmp_line_t tx, rxl, exp;
  csmp_idx_t  sidx;
  int         n_fail, n_compared, n_done, cyc;

  csmp_mbc_model i_mbc (.mclk(mclk), .olc(olc), .brdy_n(brdy_n), .sel_n(sel_n),
                        .eoc_n(eoc_n), .zbt_n(zbt_n), .data(din));
  csmp_port i_dut (.clk(clk), .reset(reset), .strobe_mode_sense(mclk),
    .output_latch_clock(olc), .burst_ready_n(brdy_n), .port_select_n(sel_n),
    .end_of_cycle_n(eoc_n), .zero_based_burst_n(zbt_n), .data_oe_n(oe_n),
    .memory_data_pins_in(din), .memory_data_pins_oe(oe), .memory_data_pins_out(dout),
    .core_tx_load(load), .core_tx_line(tx), .core_start_idx(sidx), .core_rx_line(rxl),
    .core_rx_done(done), .clocked_mode(cm), .four_xfers(four));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(logic [63:0] seen, logic [63:0] want, string msg);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(logic cfg);
    i_mbc.sel(cfg);
    reset = 1'b1;
    wt(10);
    reset = 1'b0;
    wt(6);
    i_mbc.sel(1'b1);
  endtask

  task automatic load_line(csmp_idx_t s);
    sidx = s;
    load = 1'b1;
    wt(1);
    load = 1'b0;
    wt(2);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_strobed_out;
    load_line(3'h2);
    i_mbc.sel(1'b0);
    wt(8);
    check(oe, 1'b1, "drive enable");
    oe_n = 1'b1;
    wt(4);
    check(oe, 1'b0, "drive released");
    oe_n = 1'b0;
    wt(4);
    check(dout, tx[2], "first word");
    i_mbc.ostb();
    wt(6);
    check(dout, tx[3], "second word");
    i_mbc.ostb();
    wt(6);
    check(dout, tx[0], "wrap of four");
    i_mbc.sel(1'b1);
    wt(8);
    i_mbc.ostb();
    wt(6);
    check(dout, tx[2], "strobe without select");
  endtask

  task automatic t_strobed_in;
    int k;
    k = n_done;
    i_mbc.sel(1'b0);
    wt(4);
    i_mbc.istb(8'h11);
    i_mbc.istb(8'h22);
    i_mbc.istb(8'h33);
    i_mbc.istb(8'h44);
    i_mbc.istb(8'h55);
    i_mbc.eoc(1'b0);
    wt(8);
    check(n_done, k + 1, "line done");
    check({rxl[3], rxl[2], rxl[1], rxl[0]}, 32'h22554433, "line words");
    i_mbc.sel(1'b1);
    wt(8);
    i_mbc.sel(1'b0);
    wt(8);
    check(dout, tx[0], "zero based start");
    i_mbc.sel(1'b1);
  endtask

  task automatic t_clocked;
    int k;
    do_reset(1'b0);
    check(four, 1'b0, "eight transfers");
    tx = 64'h0f1e2d3c4b5a6978;
    load_line(3'h5);
    k = n_done;
    for (int i = 0; i < 3; i++) i_mbc.mcyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    i_mbc.mcyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    wt(8);
    check(cm, 1'b1, "clocked detected");
    i_mbc.mcyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h10);
    wt(8);
    check(dout, tx[1], "clocked word");
    i_mbc.mcyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h21);
    wt(2);
    check(dout, tx[1], "latch closed");
    i_mbc.mcyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    wt(2);
    check(dout, tx[2], "latch open");
    for (int i = 2; i < 8; i++) begin
      i_mbc.mcyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, csmp_byte_t'(8'h10 + 8'h11 * i));
    end
    i_mbc.mcyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    i_mbc.mcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    wt(10);
    for (int i = 0; i < 8; i++) exp[i] = csmp_byte_t'(8'h10 + 8'h11 * i);
    check(n_done, k + 1, "clocked done");
    check(rxl, exp, "clocked line");
  endtask

  initial begin
    reset = 1'b1;
    oe_n  = 1'b0;
    load  = 1'b0;
    tx    = 64'hf7e6d5c4b3a29180;
    sidx  = 3'h0;
    do_reset(1'b1);
    check(four, 1'b1, "four transfers");
    check(cm, 1'b0, "strobed at rest");
    t_strobed_out();
    t_strobed_in();
    t_clocked();
    complete_run();
  end
endmodule
